// ===== hw/waveform_deadtime_fault_ext.sv
// Dead-time, pattern and fault extension between timer and I/O port
//
// The APB slave port was left to the implementer.
`timescale 1ns/10ps
`default_nettype none

module waveform_deadtime_fault_ext (
  input  wire logic                                    pclk,
  input  wire logic                                    presetn,
  input  wire waveform_ext_pkg::apb_req_t              apb_req,
  output var  waveform_ext_pkg::apb_rsp_t              apb_rsp,
  input  wire logic [waveform_ext_pkg::N_CH-1:0]       wg_in,
  input  wire logic                                    timer_update,
  input  wire logic                                    timer_update_lock,
  input  wire logic [waveform_ext_pkg::N_EV-1:0]       event_in,
  input  wire logic                                    debug_break_req,
  output var  logic [waveform_ext_pkg::N_PIN-1:0]      pin_out,
  output var  logic [waveform_ext_pkg::N_PIN-1:0]      pin_override_en,
  output var  logic [waveform_ext_pkg::N_PIN-1:0]      dir_clear,
  output var  logic                                    fault_active
);

  localparam int unsigned NC = waveform_ext_pkg::N_CH;
  localparam int unsigned NP = waveform_ext_pkg::N_PIN;
  localparam int unsigned RW = waveform_ext_pkg::REG_W;
  localparam int unsigned DW = waveform_ext_pkg::DT_W;

  // Debug break synchroniser
  logic [1:0] brk_sync_q;
  logic       brk;

  // Software-visible state
  logic [5:0]                       ctrl_q,    ctrl_d;
  logic [RW-1:0]                    mask_q,    mask_d;
  logic                             ign_dbg_q, ign_dbg_d;
  logic                             cbc_q,     cbc_d;
  waveform_ext_pkg::fault_act_t     act_q,     act_d;
  logic                             fdf_q,     fdf_d;
  logic                             hbv_q,     hbv_d;
  logic                             lbv_q,     lbv_d;
  logic [DW-1:0]                    deadtime_low_side_q,    deadtime_low_side_d;
  logic [DW-1:0]                    high_side_deadtime_q,    high_side_deadtime_d;
  logic [DW-1:0]                    dtlsb_q,   dtlsb_d;
  logic [DW-1:0]                    dthsb_q,   dthsb_d;
  logic [RW-1:0]                    ovr_q,     ovr_d;
  logic [waveform_ext_pkg::APB_DW-1:0] rdata_q, rdata_d;
  logic                             slverr_q,  slverr_d;
  waveform_ext_pkg::fault_state_t   state_q,   state_d;

  // Bus decode
  logic          addr_ok;
  logic [3:0]    idx;
  logic          wr_acc;
  logic          rd_setup;
  logic [RW-1:0] wbyte;
  logic [RW-1:0] rbyte;
  logic          hit;

  // Fault detection
  logic fault_en;
  logic fault_cond;
  logic copy_ok;

  // Dead-time generator outputs
  logic [NC-1:0] ls_o;
  logic [NC-1:0] hs_o;
  logic [NP-1:0] pair_mask;
  logic [NP-1:0] pin_q, pin_d;

  assign brk     = brk_sync_q[1];
  assign idx     = apb_req.paddr[5:2];
  assign addr_ok = (apb_req.paddr[1:0] == 2'b00)
                 & (apb_req.paddr[waveform_ext_pkg::APB_AW-1:6] == 2'b00);
  assign wr_acc   = apb_req.psel & apb_req.penable & apb_req.pwrite & addr_ok;
  assign rd_setup = apb_req.psel & ~apb_req.penable;
  assign wbyte    = apb_req.pwdata[RW-1:0];

  // Protection on unless action is none
  assign fault_en   = (act_q != waveform_ext_pkg::ACT_NONE);
  assign fault_cond = fault_en
                    & ((|(event_in & mask_q))
                       | (brk & ~ign_dbg_q));
  assign copy_ok    = timer_update & ~timer_update_lock;

  assign fault_active = (state_q != waveform_ext_pkg::ST_RUN);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      brk_sync_q <= 2'b00;
    end
    else
    begin
      brk_sync_q <= {brk_sync_q[0], debug_break_req};
    end
  end

  // Fault restart state machine
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      waveform_ext_pkg::ST_RUN:
      begin
        if (fault_cond)
          state_d = waveform_ext_pkg::ST_FAULT;
      end
      waveform_ext_pkg::ST_FAULT:
      begin
        if (!fault_cond && (cbc_q || !fdf_q))
          state_d = waveform_ext_pkg::ST_ARMED;
      end
      waveform_ext_pkg::ST_ARMED:
      begin
        if (fault_cond)
          state_d = waveform_ext_pkg::ST_FAULT;
        else if (timer_update)
          state_d = waveform_ext_pkg::ST_RUN;
      end
      default:
      begin
        state_d = waveform_ext_pkg::ST_FAULT;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_q <= waveform_ext_pkg::ST_RUN;
    else
      state_q <= state_d;
  end

  // Register read mux, sampled in the setup phase
  always_comb
  begin
    rbyte = waveform_ext_pkg::REG_RESET;
    hit   = 1'b1;
    unique case (idx)
      waveform_ext_pkg::IDX_CTRL:     rbyte = {2'b00, ctrl_q};
      waveform_ext_pkg::IDX_EV_MASK:  rbyte = mask_q;
      waveform_ext_pkg::IDX_FCTRL:
        rbyte = {3'b000, ign_dbg_q, 1'b0, cbc_q, act_q};
      waveform_ext_pkg::IDX_STATUS:
        rbyte = {5'b00000, fdf_q, hbv_q, lbv_q};
      waveform_ext_pkg::IDX_DT_BOTH:  rbyte = deadtime_low_side_q;
      waveform_ext_pkg::IDX_DT_BOTHB: rbyte = dtlsb_q;
      waveform_ext_pkg::IDX_DT_LS:    rbyte = deadtime_low_side_q;
      waveform_ext_pkg::IDX_DT_HS:    rbyte = high_side_deadtime_q;
      waveform_ext_pkg::IDX_DT_LSB:   rbyte = dtlsb_q;
      waveform_ext_pkg::IDX_DT_HSB:   rbyte = dthsb_q;
      waveform_ext_pkg::IDX_OVR:      rbyte = ovr_q;
      default:                        hit   = 1'b0;
    endcase
    rdata_d  = rdata_q;
    slverr_d = slverr_q;
    if (rd_setup)
    begin
      rdata_d  = {{(waveform_ext_pkg::APB_DW-RW){1'b0}}, rbyte};
      slverr_d = ~(hit & addr_ok);
      if (!(hit & addr_ok))
        rdata_d = '0;
    end
  end

  // Register writes, buffer copy and flag updates
  always_comb
  begin
    ctrl_d    = ctrl_q;
    mask_d    = mask_q;
    ign_dbg_d = ign_dbg_q;
    cbc_d     = cbc_q;
    act_d     = act_q;
    fdf_d     = fdf_q;
    hbv_d     = hbv_q;
    lbv_d     = lbv_q;
    deadtime_low_side_d    = deadtime_low_side_q;
    high_side_deadtime_d    = high_side_deadtime_q;
    dtlsb_d   = dtlsb_q;
    dthsb_d   = dthsb_q;
    ovr_d     = ovr_q;

    // Copy valid buffers at update unless locked
    if (copy_ok)
    begin
      if (lbv_q)
      begin
        deadtime_low_side_d = dtlsb_q;
        lbv_d  = 1'b0;
      end
      if (hbv_q)
      begin
        high_side_deadtime_d = dthsb_q;
        hbv_d  = 1'b0;
      end
    end

    if (wr_acc)
    begin
      unique case (idx)
        waveform_ext_pkg::IDX_CTRL:
          ctrl_d = wbyte[5:0];
        waveform_ext_pkg::IDX_EV_MASK:
          mask_d = wbyte;
        waveform_ext_pkg::IDX_FCTRL:
        begin
          ign_dbg_d = wbyte[waveform_ext_pkg::FCTRL_IGN_DBG];
          cbc_d     = wbyte[waveform_ext_pkg::FCTRL_MODE];
          act_d     = waveform_ext_pkg::fault_act_t'(
                        wbyte[waveform_ext_pkg::FCTRL_ACT_MSB:0]);
        end
        waveform_ext_pkg::IDX_STATUS:
        begin
          if (wbyte[waveform_ext_pkg::STAT_FDF])
            fdf_d = 1'b0;
          hbv_d = wbyte[waveform_ext_pkg::STAT_HBV];
          lbv_d = wbyte[waveform_ext_pkg::STAT_LBV];
        end
        waveform_ext_pkg::IDX_DT_BOTH:
        begin
          deadtime_low_side_d = wbyte;
          high_side_deadtime_d = wbyte;
        end
        waveform_ext_pkg::IDX_DT_BOTHB:
        begin
          dtlsb_d = wbyte;
          dthsb_d = wbyte;
          lbv_d   = 1'b1;
          hbv_d   = 1'b1;
        end
        waveform_ext_pkg::IDX_DT_LS:
          deadtime_low_side_d = wbyte;
        waveform_ext_pkg::IDX_DT_HS:
          high_side_deadtime_d = wbyte;
        waveform_ext_pkg::IDX_DT_LSB:
        begin
          dtlsb_d = wbyte;
          lbv_d   = 1'b1;
        end
        waveform_ext_pkg::IDX_DT_HSB:
        begin
          dthsb_d = wbyte;
          hbv_d   = 1'b1;
        end
        waveform_ext_pkg::IDX_OVR:
        begin
          if (!fdf_q)
            ovr_d = wbyte;
        end
        default:
        begin
        end
      endcase
    end

    // Detection wins over a clearing write
    if (fault_cond)
      fdf_d = 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q    <= 6'h00;
      mask_q    <= waveform_ext_pkg::REG_RESET;
      ign_dbg_q <= 1'b0;
      cbc_q     <= 1'b0;
      act_q     <= waveform_ext_pkg::ACT_NONE;
      fdf_q     <= 1'b0;
      hbv_q     <= 1'b0;
      lbv_q     <= 1'b0;
      deadtime_low_side_q    <= waveform_ext_pkg::DT_ZERO;
      high_side_deadtime_q    <= waveform_ext_pkg::DT_ZERO;
      dtlsb_q   <= waveform_ext_pkg::DT_ZERO;
      dthsb_q   <= waveform_ext_pkg::DT_ZERO;
      ovr_q     <= waveform_ext_pkg::REG_RESET;
      rdata_q   <= '0;
      slverr_q  <= 1'b0;
    end
    else
    begin
      ctrl_q    <= ctrl_d;
      mask_q    <= mask_d;
      ign_dbg_q <= ign_dbg_d;
      cbc_q     <= cbc_d;
      act_q     <= act_d;
      fdf_q     <= fdf_d;
      hbv_q     <= hbv_d;
      lbv_q     <= lbv_d;
      deadtime_low_side_q    <= deadtime_low_side_d;
      high_side_deadtime_q    <= high_side_deadtime_d;
      dtlsb_q   <= dtlsb_d;
      dthsb_q   <= dthsb_d;
      ovr_q     <= ovr_d;
      rdata_q   <= rdata_d;
      slverr_q  <= slverr_d;
    end
  end

  assign apb_rsp.pready  = 1'b1;
  assign apb_rsp.pslverr = slverr_q;
  assign apb_rsp.prdata  = rdata_q;

  // One dead-time generator per compare channel
  for (genvar i = 0; i < NC; i++)
  begin : g_dti
    logic          wave;
    logic          prev_q, prev_d;
    logic [DW-1:0] cnt_q,  cnt_d;

    assign wave = ctrl_q[waveform_ext_pkg::CTRL_COMMON] ? wg_in[0]
                                                        : wg_in[i];
    assign pair_mask[2*i]   = ctrl_q[i];
    assign pair_mask[2*i+1] = ctrl_q[i];

    always_comb
    begin
      prev_d = wave;
      cnt_d  = cnt_q;
      if (wave && !prev_q)
        cnt_d = deadtime_low_side_q;
      else if (!wave && prev_q)
        cnt_d = high_side_deadtime_q;
      else if (cnt_q != waveform_ext_pkg::DT_ZERO)
        cnt_d = cnt_q - waveform_ext_pkg::DT_ONE;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        prev_q <= 1'b0;
        cnt_q  <= waveform_ext_pkg::DT_ZERO;
      end
      else
      begin
        prev_q <= prev_d;
        cnt_q  <= cnt_d;
      end
    end

    // Both sides off while counting
    assign ls_o[i] = prev_q & (cnt_q == waveform_ext_pkg::DT_ZERO);
    assign hs_o[i] = ~prev_q & (cnt_q == waveform_ext_pkg::DT_ZERO);
  end

  // Pin values: pattern bypasses the dead-time generators
  always_comb
  begin
    pin_d = '0;
    if (ctrl_q[waveform_ext_pkg::CTRL_PATTERN])
      pin_d = deadtime_low_side_q;
    else
      for (int k = 0; k < NC; k++)
      begin
        pin_d[2*k]   = ctrl_q[k] & ls_o[k];
        pin_d[2*k+1] = ctrl_q[k] & hs_o[k];
      end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pin_q <= '0;
    else
      pin_q <= pin_d;
  end

  assign pin_out         = pin_q;
  assign pin_override_en = ctrl_q[waveform_ext_pkg::CTRL_PATTERN]
                         ? high_side_deadtime_q
                         : (ovr_q & pair_mask);
  // Mask lifted on return to run, so port directions come back
  assign dir_clear = (fault_active && act_q == waveform_ext_pkg::ACT_CLEAR_DIR)
                   ? pair_mask : '0;

endmodule

`default_nettype wire

// ===== hw/waveform_ext_pkg.sv
// Constants, register map and carrier types of the waveform extension
package waveform_ext_pkg;

  localparam int unsigned N_CH   = 4;
  localparam int unsigned N_PIN  = 8;
  localparam int unsigned N_EV   = 8;
  localparam int unsigned DT_W   = 8;
  localparam int unsigned REG_W  = 8;
  localparam int unsigned APB_AW = 8;
  localparam int unsigned APB_DW = 32;

  // Register indexes; byte address is four times the index
  localparam logic [3:0] IDX_CTRL     = 4'h0;
  localparam logic [3:0] IDX_EV_MASK  = 4'h2;
  localparam logic [3:0] IDX_FCTRL    = 4'h3;
  localparam logic [3:0] IDX_STATUS   = 4'h4;
  localparam logic [3:0] IDX_DT_BOTH  = 4'h6;
  localparam logic [3:0] IDX_DT_BOTHB = 4'h7;
  localparam logic [3:0] IDX_DT_LS    = 4'h8;
  localparam logic [3:0] IDX_DT_HS    = 4'h9;
  localparam logic [3:0] IDX_DT_LSB   = 4'hA;
  localparam logic [3:0] IDX_DT_HSB   = 4'hB;
  localparam logic [3:0] IDX_OVR      = 4'hC;

  // Field positions
  localparam int unsigned CTRL_PATTERN   = 5;
  localparam int unsigned CTRL_COMMON    = 4;
  localparam int unsigned CTRL_EN_MSB    = 3;
  localparam int unsigned FCTRL_IGN_DBG  = 4;
  localparam int unsigned FCTRL_MODE     = 2;
  localparam int unsigned FCTRL_ACT_MSB  = 1;
  localparam int unsigned STAT_FDF       = 2;
  localparam int unsigned STAT_HBV       = 1;
  localparam int unsigned STAT_LBV       = 0;

  localparam logic [REG_W-1:0] REG_RESET = 8'h00;
  localparam logic [DT_W-1:0]  DT_ZERO   = 8'h00;
  localparam logic [DT_W-1:0]  DT_ONE    = 8'h01;

  typedef enum logic [1:0] {
    ACT_NONE      = 2'h0,
    ACT_RSVD1     = 2'h1,
    ACT_RSVD2     = 2'h2,
    ACT_CLEAR_DIR = 2'h3
  } fault_act_t;

  // Gray-coded along run -> fault -> armed
  typedef enum logic [1:0] {
    ST_RUN   = 2'b00,
    ST_FAULT = 2'b01,
    ST_ARMED = 2'b11
  } fault_state_t;

  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [APB_AW-1:0] paddr;
    logic [APB_DW-1:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic              pready;
    logic              pslverr;
    logic [APB_DW-1:0] prdata;
  } apb_rsp_t;

endpackage

// ===== tb/timer_model.sv
// Timer stand-in: four compare waveforms and a wrap update pulse
`timescale 1ns/10ps
`default_nettype none
module timer_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  output logic      [3:0] wg_in,
  output logic            timer_update
);
  logic [3:0] cnt_q;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      cnt_q <= 4'h0;
    else
      cnt_q <= cnt_q + 4'h1;

  // Channel A high for 8 of 16 cycles, B..D differ
  assign wg_in = {cnt_q < 4'hC, cnt_q < 4'hA, cnt_q < 4'h6, cnt_q < 4'h8};
  assign timer_update = (cnt_q == 4'hF);
endmodule
`default_nettype wire

// ===== tb/wave_ext_asserts.sv
// Concurrent checks on the waveform extension ports
`timescale 1ns/10ps
`default_nettype none
module wave_ext_asserts (
  input wire logic                       pclk,
  input wire logic                       presetn,
  input wire waveform_ext_pkg::apb_req_t apb_req,
  input wire waveform_ext_pkg::apb_rsp_t apb_rsp,
  input wire logic [3:0]                 wg_in,
  input wire logic                       timer_update,
  input wire logic                       timer_update_lock,
  input wire logic [7:0]                 event_in,
  input wire logic                       debug_break_req,
  input wire logic [7:0]                 pin_out,
  input wire logic [7:0]                 pin_override_en,
  input wire logic [7:0]                 dir_clear,
  input wire logic                       fault_active
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_READY: assert property (apb_req.psel |-> apb_rsp.pready)
    else $error("pready low in a transfer");
  AST_ERR: assert property (apb_req.psel && apb_req.penable &&
    apb_req.paddr[1:0] != 2'h0 |-> apb_rsp.pslverr && apb_rsp.prdata == 0)
    else $error("unaligned access not refused");
  AST_UPPER: assert property (apb_req.psel && apb_req.penable |->
    apb_rsp.prdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  AST_CAUSE: assert property ($rose(fault_active) |->
    $past(|event_in) || $past(debug_break_req, 2))
    else $error("fault without a source");
  AST_HOLD: assert property ($rose(fault_active) |=> fault_active)
    else $error("fault state too short");
  AST_LEAVE: assert property ($fell(fault_active) |->
    $past(timer_update))
    else $error("fault left outside update");
  AST_DIR_IDLE: assert property (!fault_active |-> dir_clear == 8'h00)
    else $error("direction cleared outside fault");
  AST_DIR_PAIR: assert property ((((dir_clear >> 1) ^ dir_clear) & 8'h55)
    == 8'h00)
    else $error("direction clear splits a pin pair");
endmodule

bind waveform_deadtime_fault_ext wave_ext_asserts u_chk (
  .pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
  .wg_in(wg_in), .timer_update(timer_update),
  .timer_update_lock(timer_update_lock), .event_in(event_in),
  .debug_break_req(debug_break_req), .pin_out(pin_out),
  .pin_override_en(pin_override_en), .dir_clear(dir_clear),
  .fault_active(fault_active));
`default_nettype wire

// ===== tb/waveform_deadtime_fault_ext_test.sv
// Register-level tests of the waveform extension
`timescale 1ns/10ps
`default_nettype none
module waveform_deadtime_fault_ext_test;
  logic                       pclk;
  logic                       presetn;
  waveform_ext_pkg::apb_req_t req;
  waveform_ext_pkg::apb_rsp_t rsp;
  logic [3:0]                 wg;
  logic                       upd;
  logic                       lock;
  logic [7:0]                 ev;
  logic                       dbg;
  logic [7:0]                 pin;
  logic [7:0]                 ovr;
  logic [7:0]                 dclr;
  logic                       fa;
  logic [31:0]                q;
  logic                       e;
  int                         miscompares;
  int                         n_compared;
  int                         n;
  logic [7:0]                 regs [11] = '{8'h00, 8'h08, 8'h0C, 8'h10,
    8'h18, 8'h1C, 8'h20, 8'h24, 8'h28, 8'h2C, 8'h30};

  timer_model u_tim (.pclk(pclk), .presetn(presetn), .wg_in(wg),
    .timer_update(upd));
  waveform_deadtime_fault_ext u_dut (.pclk(pclk), .presetn(presetn),
    .apb_req(req), .apb_rsp(rsp), .wg_in(wg), .timer_update(upd),
    .timer_update_lock(lock), .event_in(ev), .debug_break_req(dbg),
    .pin_out(pin), .pin_override_en(ovr), .dir_clear(dclr),
    .fault_active(fa));

  always #5 pclk = ~pclk;

  task chk(input string s, input logic [31:0] seen, input logic [31:0] x);
    n_compared++;
    if (seen !== x)
    begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", s, x, seen);
    end
  endtask

  task xf(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge pclk);
    req.penable <= 1'b1;
    do
      @(posedge pclk);
    while (rsp.pready !== 1'b1);
    q = rsp.prdata;
    e = rsp.pslverr;
    req <= '0;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    xf(1'b1, a, d);
  endtask

  task rc(input logic [7:0] a, input logic [31:0] x);
    xf(1'b0, a, 32'h0);
    chk("prdata", q, x);
  endtask

  task wait_upd();
    do
      @(negedge pclk);
    while (upd !== 1'b1);
    @(negedge pclk);
  endtask

  task wfa(input logic v);
    n = 0;
    while (fa !== v && n < 64)
    begin
      @(negedge pclk);
      n++;
    end
    chk("fault_active", fa, v);
  endtask

  task pulse(input logic [7:0] v);
    @(posedge pclk) ev <= v;
    @(posedge pclk) ev <= 8'h00;
  endtask

  // Cycles from a waveform edge to the side pin going high
  task dt(input logic lv, input int p);
    n = 0;
    while (wg[0] !== ~lv) @(negedge pclk);
    while (wg[0] !== lv) @(negedge pclk);
    while (pin[p] !== 1'b1 && n < 40)
    begin
      @(negedge pclk);
      n++;
    end
    chk("dead_time", n, 32'h5);
  endtask

  task complete_run();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial
  begin
    pclk = 1'b0;
    presetn = 1'b0;
    req = '0;
    lock = 1'b0;
    ev = 8'h00;
    dbg = 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    foreach (regs[i]) rc(regs[i], 32'h0);
    xf(1'b0, 8'h04, 32'h0);
    chk("pslverr", e, 1'b1);
    xf(1'b0, 8'h01, 32'h0);
    chk("pslverr", e, 1'b1);
    chk("prdata", q, 32'h0);
    wr(8'h00, 32'hFF);
    rc(8'h00, 32'h3F);
    wr(8'h0C, 32'hFF);
    rc(8'h0C, 32'h17);
    wr(8'h0C, 32'h00);
    wr(8'h00, 32'h00);
    $display("registers test done");
    wr(8'h18, 32'h05);
    rc(8'h20, 32'h05);
    rc(8'h24, 32'h05);
    @(posedge pclk) lock <= 1'b1;
    wr(8'h1C, 32'h03);
    rc(8'h28, 32'h03);
    rc(8'h2C, 32'h03);
    rc(8'h10, 32'h03);
    wait_upd();
    rc(8'h20, 32'h05);
    rc(8'h10, 32'h03);
    @(posedge pclk) lock <= 1'b0;
    wait_upd();
    rc(8'h20, 32'h03);
    rc(8'h24, 32'h03);
    rc(8'h10, 32'h00);
    $display("buffer test done");
    wr(8'h00, 32'h01);
    dt(1'b1, 0);
    dt(1'b0, 1);
    wr(8'h00, 32'h13);
    repeat (8) @(negedge pclk);
    n = 0;
    repeat (32)
    begin
      @(negedge pclk);
      if (pin[3:2] !== pin[1:0])
        n++;
    end
    chk("common_pins", n, 32'h0);
    $display("dead time test done");
    wr(8'h08, 32'h01);
    wr(8'h0C, 32'h03);
    pulse(8'h01);
    wfa(1'b1);
    chk("dir_clear", dclr, 32'h0F);
    rc(8'h10, 32'h04);
    wr(8'h30, 32'hFF);
    rc(8'h30, 32'h00);
    wait_upd();
    wait_upd();
    chk("fault_active", fa, 1'b1);
    wr(8'h10, 32'h04);
    wfa(1'b0);
    chk("dir_clear", dclr, 32'h00);
    rc(8'h10, 32'h00);
    wr(8'h30, 32'hFF);
    rc(8'h30, 32'hFF);
    wr(8'h30, 32'h00);
    $display("latched fault test done");
    wr(8'h0C, 32'h07);
    pulse(8'h02);
    repeat (3) @(negedge pclk);
    chk("fault_active", fa, 1'b0);
    @(posedge pclk) dbg <= 1'b1;
    wfa(1'b1);
    @(posedge pclk) dbg <= 1'b0;
    wfa(1'b0);
    wr(8'h10, 32'h04);
    wr(8'h0C, 32'h17);
    @(posedge pclk) dbg <= 1'b1;
    repeat (8) @(negedge pclk);
    chk("fault_active", fa, 1'b0);
    @(posedge pclk) dbg <= 1'b0;
    wr(8'h0C, 32'h04);
    pulse(8'h01);
    repeat (4) @(negedge pclk);
    chk("fault_active", fa, 1'b0);
    rc(8'h10, 32'h00);
    $display("restart test done");
    wr(8'h00, 32'h20);
    wr(8'h20, 32'hA5);
    wr(8'h24, 32'h3C);
    repeat (3) @(negedge pclk);
    chk("pin_out", pin, 32'hA5);
    chk("pin_override_en", ovr, 32'h3C);
    $display("pattern test done");
    complete_run();
  end

  initial
  begin
    #100000;
    miscompares++;
    complete_run();
  end
endmodule
`default_nettype wire
